// ==== rtl/psk_select_top.sv ====
// peripheral select decoder and keyboard read path
// assumes processor address, data, rw and phase2 on clk; keys from pins
`timescale 1ns/100ps
`default_nettype none
// How it works
// - untouched rank reads as zero byte
// - rank r bit n is key 8r+n, one-hot
// - decode returns key in two results
// - no key gives hex 18 code
// - different key clears new-key flag
// - release to no-key never clears the flag
// - strobe low on x880 to x8F0 accesses
// - display select low on x820 writes
// - output port select low on x840 writes
// - tape select low on x9xx writes only
// - connector data lines ascend lsb to msb
// - enables come from memory accesses only
// - top address nibble is ignored
// - ranks at x801, x802, x803
// - output select loads output port latches
module psk_select_top
  import psk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_rw,
  input  wire logic        cpu_phase2,
  output logic [7:0]       cpu_rdata,
  output logic             cpu_rvalid,
  input  wire logic [23:0] key_pins,
  input  wire logic        scan_start,
  output logic             scan_busy,
  output logic             scan_done,
  output logic [7:0]       key_code_a,
  output logic [7:0]       key_code_y,
  output logic [7:0]       key_index,
  output logic             new_key,
  output logic [7:0]       connector_data_lines,
  output logic             strobe_select_n,
  output logic             display_select_n,
  output logic             output_port_select_n,
  output logic             tape_select_n,
  output logic [7:0]       output_port_data
);

  psk_key_if kif ();

  logic [23:0] key_s1_r;
  logic [23:0] key_s2_r;
  logic [23:0] key_s3_r;
  logic [23:0] key_r;
  logic        strb_nxt;
  logic        disp_nxt;
  logic        outp_nxt;
  logic        tape_nxt;
  logic        access;
  logic        wr;
  logic [11:0] low_addr;
  logic [7:0]  rank_nxt;

  // ----------------------------------------
  // key pin synchroniser, change taken when stages 2 and 3 agree
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      key_s1_r <= 24'h000000;
      key_s2_r <= 24'h000000;
      key_s3_r <= 24'h000000;
      key_r    <= 24'h000000;
    end
    else
    begin
      key_s1_r <= key_pins;
      key_s2_r <= key_s1_r;
      key_s3_r <= key_s2_r;
      for (int i = 0; i < PSK_KEY_COUNT; i++)
        if (key_s2_r[i] == key_s3_r[i])
          key_r[i] <= key_s3_r[i];
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign low_addr = cpu_addr[11:0];
  assign access   = cpu_phase2;
  assign wr       = access && !cpu_rw;

  always_comb
  begin
    strb_nxt = access && (low_addr[11:4] >= PSK_STRB_HI) && (low_addr[11:8] == 4'h8)
               && (low_addr[3:0] == 4'h0);
    disp_nxt = wr && (low_addr == PSK_DISP_ADDR);
    outp_nxt = wr && (low_addr == PSK_OUTP_ADDR);
    tape_nxt = wr && (low_addr[11:8] == PSK_TAPE_PAGE);
  end

  // selects registered, held high in reset and outside phase2
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      strobe_select_n      <= 1'b1;
      display_select_n     <= 1'b1;
      output_port_select_n <= 1'b1;
      tape_select_n        <= 1'b1;
    end
    else
    begin
      strobe_select_n      <= !strb_nxt;
      display_select_n     <= !disp_nxt;
      output_port_select_n <= !outp_nxt;
      tape_select_n        <= !tape_nxt;
    end
  end

  // ----------------------------------------
  // data lines and output port latch
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      connector_data_lines <= PSK_DATA_RST;
      output_port_data     <= PSK_DATA_RST;
    end
    else
    begin
      // rank byte taken straight from decode so the lines never lag the read
      connector_data_lines <= cpu_rw ? rank_nxt : cpu_wdata;
      if (!output_port_select_n)
        output_port_data <= connector_data_lines;
    end
  end

  // ----------------------------------------
  // rank read path
  // ----------------------------------------
  // rank byte for an address, zero off the rank map
  function automatic logic [7:0] rank_of(input logic [11:0] a, input logic [23:0] k);
    logic [7:0] r;
    case (a)
      PSK_RANK0_ADDR: r = k[7:0];
      PSK_RANK1_ADDR: r = k[15:8];
      PSK_RANK2_ADDR: r = k[23:16];
      default:        r = PSK_IDLE_RANK;
    endcase
    return r;
  endfunction : rank_of

  // shared by read data and connector lines
  assign rank_nxt = rank_of(low_addr, key_r);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cpu_rdata  <= PSK_IDLE_RANK;
      cpu_rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= access && cpu_rw;
      cpu_rdata  <= rank_nxt;
    end
  end

  // ----------------------------------------
  // key decode
  // ----------------------------------------
  assign kif.start = scan_start;
  assign kif.keys  = key_r;

  psk_key_decode u_dec (
    .clk  (clk),
    .rstn (rstn),
    .kif  (kif)
  );

  assign scan_busy  = kif.busy;
  assign scan_done  = kif.done;
  assign key_code_a = kif.key_a;
  assign key_code_y = kif.key_y;
  assign key_index  = kif.index;
  assign new_key    = kif.new_key;

  a_disp_write : assert property (@(posedge clk) disable iff (!rstn)
    !display_select_n |-> $past(wr && low_addr == PSK_DISP_ADDR))
    else $error("display select without write");
  a_outp_write : assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase2 && cpu_rw) |=> output_port_select_n)
    else $error("output select on read");
  a_tape_write : assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase2 && !cpu_rw && cpu_addr[11:8] == 4'h9) |=> !tape_select_n)
    else $error("tape select missing");
  a_strobe_any : assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase2 && cpu_addr[11:7] == 5'h11 && cpu_addr[3:0] == 4'h0) |=> !strobe_select_n)
    else $error("strobe missing");
  a_phase_idle : assert property (@(posedge clk) disable iff (!rstn)
    !cpu_phase2 |=> (strobe_select_n && display_select_n && output_port_select_n && tape_select_n))
    else $error("select outside phase2");
  a_rank_zero : assert property (@(posedge clk) disable iff (!rstn)
    (low_addr == PSK_RANK0_ADDR && key_r[7:0] == 8'h00) |=> cpu_rdata == 8'h00)
    else $error("idle rank not zero");
  a_outp_load : assert property (@(posedge clk) disable iff (!rstn)
    !output_port_select_n |=> output_port_data == $past(connector_data_lines))
    else $error("port latch not loaded");
  a_conn_read : assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase2 && cpu_rw) |=> connector_data_lines == cpu_rdata)
    else $error("connector lost read data");
  a_rank_map : assert property (@(posedge clk) disable iff (!rstn)
    (low_addr == PSK_RANK1_ADDR) |=> cpu_rdata == $past(key_r[15:8]))
    else $error("rank byte misplaced");
  a_read_quiet : assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase2 && cpu_rw) |=> (display_select_n && tape_select_n))
    else $error("write select on read");

endmodule : psk_select_top
`default_nettype wire

// ==== rtl/psk_pkg.sv ====
// package for the peripheral select and key decode block
// assumes a byte-wide processor bus with 16-bit addresses on one clock
package psk_pkg;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  localparam logic [11:0] PSK_RANK0_ADDR  = 12'h801;
  localparam logic [11:0] PSK_RANK1_ADDR  = 12'h802;
  localparam logic [11:0] PSK_RANK2_ADDR  = 12'h803;
  localparam logic [11:0] PSK_DISP_ADDR   = 12'h820;
  localparam logic [11:0] PSK_OUTP_ADDR   = 12'h840;
  localparam logic [7:0]  PSK_STRB_HI     = 8'h88;
  localparam logic [3:0]  PSK_TAPE_PAGE   = 4'h9;

  // ----------------------------------------
  // key decode
  // ----------------------------------------
  localparam int          PSK_KEY_COUNT   = 24;
  localparam logic [7:0]  PSK_NO_KEY      = 8'h18;
  localparam logic [7:0]  PSK_IDLE_RANK   = 8'h00;
  localparam logic [7:0]  PSK_DATA_RST    = 8'h00;

  typedef enum logic [1:0] {PSK_ST_IDLE, PSK_ST_SCAN, PSK_ST_DONE} psk_state_t;

endpackage : psk_pkg

// ==== rtl/psk_key_if.sv ====
// interface joining the select top and the key decode module
// assumes both ends on clk
`timescale 1ns/100ps
`default_nettype none
interface psk_key_if;
  logic        start;
  logic [23:0] keys;
  logic        busy;
  logic        done;
  logic [7:0]  key_a;
  logic [7:0]  key_y;
  logic [7:0]  index;
  logic        new_key;

  modport top (output start, output keys, input busy, input done, input key_a, input key_y, input index,
               input new_key);
  modport dec (input start, input keys, output busy, output done, output key_a, output key_y, output index,
               output new_key);
endinterface : psk_key_if
`default_nettype wire

// ==== rtl/psk_key_decode.sv ====
// whole-keyboard decode: scans 24 key lines, returns key number twice
// assumes key lines already synchronised by the caller
`timescale 1ns/100ps
`default_nettype none
module psk_key_decode
  import psk_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  psk_key_if.dec    kif
);

  psk_state_t state_r;
  logic [7:0] idx_r;
  logic [7:0] found_r;
  logic [7:0] prev_r;
  logic [7:0] key_a_r;
  logic [7:0] key_y_r;
  logic       flag_r;
  logic [23:0] keys_r;

  // ----------------------------------------
  // scan walk, one key per cycle, lowest key wins
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= PSK_ST_IDLE;
      idx_r   <= 8'h00;
      found_r <= PSK_NO_KEY;
      keys_r  <= 24'h000000;
    end
    else
    begin
      case (state_r)
        PSK_ST_IDLE:
        begin
          if (kif.start)
          begin
            state_r <= PSK_ST_SCAN;
            idx_r   <= 8'h00;
            found_r <= PSK_NO_KEY;
            keys_r  <= kif.keys;
          end
        end
        PSK_ST_SCAN:
        begin
          if (keys_r[idx_r[4:0]] && found_r == PSK_NO_KEY)
            found_r <= idx_r;
          if (idx_r == 8'(PSK_KEY_COUNT - 1))
            state_r <= PSK_ST_DONE;
          else
            idx_r <= idx_r + 8'h01;
        end
        PSK_ST_DONE:
          state_r <= PSK_ST_IDLE;
        default:
          state_r <= PSK_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // results and new-key flag
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prev_r  <= PSK_NO_KEY;
      key_a_r <= PSK_NO_KEY;
      key_y_r <= PSK_NO_KEY;
      flag_r  <= 1'b1;
    end
    else if (state_r == PSK_ST_DONE)
    begin
      key_a_r <= found_r;
      key_y_r <= found_r;
      prev_r  <= found_r;
      // release to no-key keeps the flag, only a fresh key clears it
      if (found_r != prev_r && found_r != PSK_NO_KEY)
        flag_r <= 1'b0;
      else
        flag_r <= 1'b1;
    end
  end

  assign kif.busy    = (state_r != PSK_ST_IDLE);
  assign kif.done    = (state_r == PSK_ST_DONE);
  assign kif.key_a   = key_a_r;
  assign kif.key_y   = key_y_r;
  assign kif.index   = idx_r; // scratch, no key meaning
  assign kif.new_key = ~flag_r;

  a_nokey_code : assert property (@(posedge clk) disable iff (!rstn)
    (kif.start && !kif.busy && kif.keys == 24'h000000) |-> ##26 (key_a_r == PSK_NO_KEY && key_y_r == PSK_NO_KEY))
    else $error("no-key code missing");
  a_both_equal : assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PSK_ST_DONE) |=> (key_a_r == $past(found_r) && key_y_r == $past(found_r)))
    else $error("result copies differ");
  a_same_keeps : assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PSK_ST_DONE && found_r == prev_r) |=> flag_r)
    else $error("held key cleared flag");
  a_new_clears : assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PSK_ST_DONE && found_r != prev_r && found_r != PSK_NO_KEY) |=> !flag_r)
    else $error("new key kept flag");
  a_release_keeps : assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PSK_ST_DONE && found_r == PSK_NO_KEY) |=> flag_r)
    else $error("release cleared flag");
  a_prev_track : assert property (@(posedge clk) disable iff (!rstn)
    (state_r == PSK_ST_DONE) |=> (prev_r == $past(found_r)))
    else $error("previous key not updated");

endmodule : psk_key_decode
`default_nettype wire

// ==== tb/psk_cpu_model.sv ====
// processor bus model: one access per call, phase2 high for one cycle
// assumes the block samples on rising clk; lines move on falling clk
`timescale 1ns/100ps
`default_nettype none
module psk_cpu_model
(
  input  wire logic       clk,
  output logic [15:0]     cpu_addr,
  output logic [7:0]      cpu_wdata,
  output logic            cpu_rw,
  output logic            cpu_phase2,
  input  wire logic [7:0] cpu_rdata,
  input  wire logic       cpu_rvalid
);
  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  initial
  begin
    cpu_addr   = 16'h0000;
    cpu_wdata  = 8'h00;
    cpu_rw     = 1'b1;
    cpu_phase2 = 1'b0;
  end

  // released address and data lines show the inverse so a stale value never passes
  task automatic access(input logic [15:0] a, input logic [7:0] d, input logic rw, output logic [7:0] rd);
    @(negedge clk);
    cpu_addr   = a;
    cpu_wdata  = d;
    cpu_rw     = rw;
    cpu_phase2 = 1'b1;
    @(negedge clk);
    rd         = (cpu_rvalid === 1'b1) ? cpu_rdata : 8'hXX;
    cpu_phase2 = 1'b0;
    cpu_addr   = ~a;
    cpu_wdata  = ~d;
  endtask : access
endmodule : psk_cpu_model
`default_nettype wire

// ==== tb/psk_select_top_test.sv ====
// testbench for the peripheral select and key decode block
// assumes psk_pkg, the key interface and the bus model are compiled first
`timescale 1ns/100ps
`default_nettype none
module psk_select_top_test;
  import psk_pkg::*;
  logic        clk;
  logic        rstn;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        cpu_rw;
  logic        cpu_phase2;
  logic [7:0]  cpu_rdata;
  logic        cpu_rvalid;
  logic [23:0] key_pins;
  logic        scan_start;
  logic        scan_busy;
  logic        scan_done;
  logic [7:0]  key_code_a;
  logic [7:0]  key_code_y;
  logic [7:0]  key_index;
  logic        new_key;
  logic [7:0]  conn;
  logic [3:0]  sel;
  logic [7:0]  port_q;
  int          n_fail;
  int          cmp_count;

  psk_cpu_model cpu_u (.clk(clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rw(cpu_rw),
    .cpu_phase2(cpu_phase2), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid));
  psk_select_top dut_u (.clk(clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rw(cpu_rw), .cpu_phase2(cpu_phase2), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .key_pins(key_pins), .scan_start(scan_start), .scan_busy(scan_busy), .scan_done(scan_done),
    .key_code_a(key_code_a), .key_code_y(key_code_y), .key_index(key_index), .new_key(new_key),
    .connector_data_lines(conn), .strobe_select_n(sel[3]), .display_select_n(sel[2]),
    .output_port_select_n(sel[1]), .tape_select_n(sel[0]), .output_port_data(port_q));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // key lines cross a synchroniser, so allow it to settle
  task automatic set_keys(input logic [23:0] k);
    @(negedge clk);
    key_pins = k;
    repeat (8) @(negedge clk);
  endtask : set_keys

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ranks;
    logic [7:0] rd;
    for (int r = 0; r < 3; r++)
    begin
      set_keys(24'h000000);
      cpu_u.access({4'(r * 5), 12'h801 + 12'(r)}, 8'h00, 1'b1, rd);
      chk("idle rank", 8'h00, rd);
      for (int k = 0; k < 8; k++)
      begin
        set_keys(24'h000001 << (r * 8 + k));
        cpu_u.access({4'(k), 12'h801 + 12'(r)}, 8'h00, 1'b1, rd);
        chk("rank bit", 8'h01 << k, rd);
        chk("connector read", 8'h01 << k, conn);
      end
    end
  endtask : t_ranks

  task automatic t_selects;
    logic [7:0]  rd;
    logic [20:0] tb [10] = '{{1'b0, 4'hB, 16'h5820}, {1'b1, 4'hF, 16'h0820}, {1'b0, 4'hD, 16'hA840},
      {1'b1, 4'hF, 16'hF840}, {1'b0, 4'hE, 16'h0900}, {1'b0, 4'hE, 16'h79FF}, {1'b1, 4'hF, 16'h1955},
      {1'b0, 4'hF, 16'h0881}, {1'b1, 4'hF, 16'h0870}, {1'b0, 4'hF, 16'h0A00}};
    for (int i = 0; i < 16; i++)
    begin
      cpu_u.access({4'(i * 3), 4'h8, 4'(8 + i / 2), 4'h0}, 8'h3C, 1'(i), rd);
      chk("strobe sel", 8'h07, {4'h0, sel});
      @(negedge clk);
      chk("sel idle", 8'h0F, {4'h0, sel});
    end
    for (int i = 0; i < 10; i++)
    begin
      cpu_u.access(tb[i][15:0], 8'h5A, tb[i][20], rd);
      chk("sel map", {4'h0, tb[i][19:16]}, {4'h0, sel});
      @(negedge clk);
      chk("sel idle", 8'h0F, {4'h0, sel});
    end
  endtask : t_selects

  task automatic t_output_port_select_n(input logic [7:0] d);
    logic [7:0] rd;
    cpu_u.access(16'hC840, d, 1'b0, rd);
    chk("connector write", d, conn);
    @(negedge clk);
    chk("port latch", d, port_q);
  endtask : t_output_port_select_n

  // a second start mid-scan must be ignored, or done timing moves
  task automatic t_scan(input logic [23:0] k, input logic [7:0] code, input logic nk);
    int n;
    set_keys(k);
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
    chk("busy", 8'h01, {7'h00, scan_busy});
    n = 1;
    repeat (4) @(negedge clk);
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
    n = 6;
    while (scan_done !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk("done cycle", 8'h19, 8'(n));
    @(negedge clk);
    chk("key a", code, key_code_a);
    chk("key y", code, key_code_y);
    chk("new key", {7'h00, nk}, {7'h00, new_key});
    chk("index scratch", 8'(PSK_KEY_COUNT - 1), key_index);
  endtask : t_scan

  // reset mid-run: a write in reset stays quiet, key history returns to no-key
  task automatic t_reset;
    logic [7:0] rd;
    @(negedge clk);
    rstn = 1'b0;
    cpu_u.access(16'h0840, 8'hA5, 1'b0, rd);
    chk("reset sel", 8'h0F, {4'h0, sel});
    chk("reset key", PSK_NO_KEY, key_code_a);
    chk("reset new", 8'h00, {7'h00, new_key});
    rstn = 1'b1;
  endtask : t_reset

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    n_fail     = 0;
    cmp_count  = 0;
    rstn       = 1'b0;
    key_pins   = 24'h000000;
    scan_start = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    chk("reset sel", 8'h0F, {4'h0, sel});
    chk("reset key", 8'h18, key_code_a);
    t_ranks();
    t_selects();
    t_output_port_select_n(8'h01);
    t_output_port_select_n(8'h80);
    t_scan(24'h000000, 8'h18, 1'b0);
    t_scan(24'h000020, 8'h05, 1'b1);
    t_scan(24'h000020, 8'h05, 1'b0);
    t_scan(24'h000000, 8'h18, 1'b0);
    t_scan(24'h020200, 8'h09, 1'b1);
    t_scan(24'h800000, 8'h17, 1'b1);
    t_scan(24'h000001, 8'h00, 1'b1);
    t_reset();
    t_scan(24'h000001, 8'h00, 1'b1);
    final_report();
  end

  initial
  begin
    #(5000 * 20);
    n_fail++;
    final_report();
  end
endmodule : psk_select_top_test
`default_nettype wire
